// ### bench/link_props.sv
// Assertions on the control link joining a relay node and its peer
`timescale 1ns/1ns
`default_nettype none
module link_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] ctl_to_peer,
    input wire logic ctl_to_peer_stb,
    input wire logic [1:0] ctl_from_peer,
    input wire logic ctl_from_peer_stb
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_to_pulse;
        ctl_to_peer_stb |=> !ctl_to_peer_stb;
    endproperty
    a_to_pulse: assert property (p_to_pulse) else $error("to strobe long");
    property p_from_pulse;
        ctl_from_peer_stb |=> !ctl_from_peer_stb;
    endproperty
    a_from_pulse: assert property (p_from_pulse) else $error("from strobe long");
    property p_to_hold;
        $changed(ctl_to_peer) |-> ctl_to_peer_stb;
    endproperty
    a_to_hold: assert property (p_to_hold) else $error("to data moved");
    property p_from_hold;
        $changed(ctl_from_peer) |-> ctl_from_peer_stb;
    endproperty
    a_from_hold: assert property (p_from_hold) else $error("from data moved");
    // Slow sources leave three quiet cycles after every send to the peer
    property p_to_quiet;
        ctl_to_peer_stb |=> $stable(ctl_to_peer) [*3];
    endproperty
    a_to_quiet: assert property (p_to_quiet) else $error("to resent early");
    property p_rel;
        $rose(rst_n) |-> !ctl_to_peer_stb && !ctl_from_peer_stb;
    endproperty
    a_rel: assert property (p_rel) else $error("strobe at release");
    c_to: cover property (ctl_to_peer_stb);
    c_from: cover property (ctl_from_peer_stb);
    c_both: cover property (ctl_to_peer_stb ##[1:40] ctl_from_peer_stb);
endmodule // link_props
`default_nettype wire

// ### bench/tb_top.sv
// Bench joining a relay node to its peer over the control link
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import relay_pkg::*;
;
    localparam int HC = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic irq;
    logic usb_power = 1'b1;
    logic ext_power = 1'b0;
    logic [1:0] host_ctl_in = 2'h0;
    logic [1:0] host_ctl_out;
    logic [NPINS-1:0] ext_pins = '1;
    wire [NPINS-1:0] pin_in;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe_n;
    logic rx_bad_stop = 1'b0;
    logic rx_byte_dropped = 1'b0;
    logic rx_enable;
    logic [1:0] peer_out_ctl = 2'h0;
    logic [1:0] peer_in_ctl;
    int fails = 0;
    int samples_checked = 0;
    // Released pins follow ext_pins, which start high; a driven pin shows the node's level
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_pins);
    relay_if lnk ();
    relay_node #(.HOLDOFF_MS_CYCLES(HC)) relay_node_i (.clk(clk),
        .rst_n(rst_n), .link(lnk), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .usb_power(usb_power),
        .ext_power(ext_power), .host_ctl_in(host_ctl_in),
        .host_ctl_out(host_ctl_out), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .rx_bad_stop(rx_bad_stop),
        .rx_byte_dropped(rx_byte_dropped), .rx_enable(rx_enable));
    relay_peer relay_peer_i (.clk(clk), .rst_n(rst_n), .link(lnk),
        .peer_out_ctl(peer_out_ctl), .peer_in_ctl(peer_in_ctl));
    link_props link_props_i (.clk(clk), .rst_n(rst_n),
        .ctl_to_peer(lnk.ctl_to_peer), .ctl_to_peer_stb(lnk.ctl_to_peer_stb),
        .ctl_from_peer(lnk.ctl_from_peer),
        .ctl_from_peer_stb(lnk.ctl_from_peer_stb));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic conclude;
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        step(1);
        chk({pin_oe_n[11:8], pin_out[9:8]}, 6'h33);
        chk({pin_oe_n[0], pin_out[0]}, 2'h0);
        rd_reg(REG_ROUTE, d);
        chk(d, 32'h0);
        rd_reg(REG_CHANNEL, d);
        chk(d, 32'h80);
        rd_reg(REG_BAUD, d);
        chk(d, 32'h2580);
        rd_reg(REG_HOLDOFF, d);
        chk(d, 32'h0);
        rd_reg(4'h7, d);
        chk(d, 32'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) {ext_power, usb_power} <= i[1:0];
            step(3);
            rd_reg(REG_CTRL, d);
            chk(d[5:4], (i == 0) ? 2'h1 : i[1:0]);
        end
        wr_reg(REG_ROUTE, 32'h1);
        host_ctl_in <= 2'h1;
        step(8);
        chk(lnk.ctl_to_peer, 2'h1);
        chk(peer_in_ctl, 2'h1);
        @(posedge clk) peer_out_ctl <= 2'h2;
        step(8);
        chk(host_ctl_out, 2'h2);
        wr_reg(REG_ROUTE, 32'h2);
        ext_pins[11] <= 1'b0;
        step(8);
        chk(peer_in_ctl, 2'h2);
        @(posedge clk) peer_out_ctl <= 2'h1;
        step(8);
        chk(pin_out[9:8], 2'h2);
        wr_reg(REG_ROUTE, 32'h3);
        host_ctl_in <= 2'h2;
        ext_pins[11:10] <= 2'h2;
        step(8);
        chk(pin_out[9:8], 2'h1);
        chk(host_ctl_out, 2'h1);
        chk(peer_in_ctl, 2'h2);
        // Code 21 is port 2 bit 1, pin index 17
        wr_reg(4'h8, 32'h15);
        step(2);
        chk({pin_oe_n[17], pin_oe_n[8], pin_out[17]}, 3'h3);
        wr_reg(4'h8, 32'hFF);
        step(2);
        chk(pin_oe_n[17], 1'b1);
        wr_reg(4'hA, 32'hFF);
        wr_reg(4'hE, 32'h0C);
        ext_pins[10] <= 1'b1;
        step(3);
        chk(host_ctl_out, 2'h1);
        wr_reg(REG_CTRL, 32'h1);
        step(1);
        chk({pin_oe_n[0], pin_out[0]}, 2'h1);
        wr_reg(REG_HOLDOFF, 32'hFF);
        rd_reg(REG_HOLDOFF, d);
        chk(d, 32'hFA);
        wr_reg(REG_HOLDOFF, 32'h3);
        @(posedge clk) rx_bad_stop <= 1'b1;
        @(posedge clk) rx_bad_stop <= 1'b0;
        step(1);
        chk(rx_enable, 1'b0);
        step(3 * HC - 2);
        chk(rx_enable, 1'b0);
        step(1);
        chk(rx_enable, 1'b1);
        @(posedge clk) rx_byte_dropped <= 1'b1;
        @(posedge clk) rx_byte_dropped <= 1'b0;
        rd_reg(REG_STATUS, d);
        chk(d, 32'h7);
        chk(irq, 1'b0);
        wr_reg(REG_MASK, 32'h6);
        step(1);
        chk(irq, 1'b1);
        wr_reg(REG_STATUS, 32'h7);
        step(1);
        chk(irq, 1'b0);
        conclude();
    end
    // Tests need about 155 cycles; the limit leaves ample margin
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule // tb_top
`default_nettype wire

// ### rtl/relay_if.sv
// Radio-side link between a relay node and its peer
`timescale 1ns/1ns
`default_nettype none
interface relay_if;
    logic [1:0] ctl_to_peer;
    logic ctl_to_peer_stb;
    logic [1:0] ctl_from_peer;
    logic ctl_from_peer_stb;
    modport node (output ctl_to_peer, output ctl_to_peer_stb,
        input ctl_from_peer, input ctl_from_peer_stb);
    modport peer (input ctl_to_peer, input ctl_to_peer_stb,
        output ctl_from_peer, output ctl_from_peer_stb);
endinterface
`default_nettype wire

// ### rtl/relay_node.sv
// Relay node: routing, pin mapping, hold-off and registers
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module relay_node
    import relay_pkg::*;
#(
    parameter int HOLDOFF_MS_CYCLES = MS_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    relay_if.node link,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    input wire logic usb_power,
    input wire logic ext_power,
    input wire logic [1:0] host_ctl_in,
    output logic [1:0] host_ctl_out,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe_n,
    input wire logic rx_bad_stop,
    input wire logic rx_byte_dropped,
    output logic rx_enable
);
    route_t route_r;
    route_t active;
    logic [7:0] channel_r;
    logic [23:0] baud_r;
    logic [7:0] holdoff_r;
    logic [ST_W-1:0] status_r;
    logic [ST_W-1:0] mask_r;
    logic prog_rst_r;
    pin_code_t assign_r [0:8];
    logic [1:0] out_val_r;
    logic [1:0] host_val_r;
    logic [1:0] sent_r;
    logic [7:0] ms_left_r;
    logic [31:0] tick_r;
    logic [1:0] in_val;
    logic [1:0] send_val;
    logic send_now;
    logic [ST_W-1:0] events;
    logic [31:0] rd_mux;
    // Live choice so a cable plugged in later switches routing
    always_comb begin
        if (route_r != ROUTE_AUTO) begin
            active = route_r;
        end else if (usb_power && ext_power) begin
            active = HOST_TO_WIRED_ROUTING;
        end else if (ext_power) begin
            active = WIRED_TO_RF_ROUTING;
        end else begin
            active = HOST_TO_RF_ROUTING;
        end
    end
    function automatic logic [4:0] pin_idx(input pin_code_t c);
        return 5'((c / PIN_DIGIT_SCALE) * 8 + (c % PIN_DIGIT_SCALE));
    endfunction
    // Bit digits 8 and 9 name no pin; refusing them stops aliasing
    function automatic logic pin_ok(input pin_code_t c);
        return c >= 0 && (c % PIN_DIGIT_SCALE) < 8 &&
            (c / PIN_DIGIT_SCALE) * 8 + (c % PIN_DIGIT_SCALE) < NPINS;
    endfunction
    function automatic logic pin_level(input pin_code_t c,
        input logic [NPINS-1:0] p);
        if (!pin_ok(c)) begin
            return 1'b0;
        end
        return p[pin_idx(c)];
    endfunction
    // Slot order: inv out a,b; inv in a,b; true out a,b; true in a,b; prog
    always_comb begin
        // Only one input assignment per signal is enabled by software
        in_val[0] = (assign_r[2] != PIN_OFF) ?
            ~pin_level(assign_r[2], pin_in) :
            pin_level(assign_r[6], pin_in);
        in_val[1] = (assign_r[3] != PIN_OFF) ?
            ~pin_level(assign_r[3], pin_in) :
            pin_level(assign_r[7], pin_in);
        pin_out = '0;
        pin_oe_n = '1;
        for (int s = 0; s < 2; s++) begin
            if (pin_ok(assign_r[s])) begin
                pin_out[pin_idx(assign_r[s])] = ~out_val_r[s];
                pin_oe_n[pin_idx(assign_r[s])] = 1'b0;
            end
            if (pin_ok(assign_r[s+4])) begin
                pin_out[pin_idx(assign_r[s+4])] = out_val_r[s];
                pin_oe_n[pin_idx(assign_r[s+4])] = 1'b0;
            end
        end
        if (pin_ok(assign_r[8])) begin
            pin_out[pin_idx(assign_r[8])] = prog_rst_r;
            pin_oe_n[pin_idx(assign_r[8])] = 1'b0;
        end
    end
    assign send_val = (active == HOST_TO_RF_ROUTING) ? host_ctl_in :
        in_val;
    assign send_now = (active != HOST_TO_WIRED_ROUTING) &&
        (send_val != sent_r);
    assign events = {rx_byte_dropped, rx_bad_stop,
        link.ctl_from_peer_stb};
    assign irq = |(status_r & mask_r);
    assign rx_enable = (ms_left_r == 8'h00);
    assign host_ctl_out = host_val_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_val_r <= 2'h0;
            host_val_r <= 2'h0;
        end else if (active == HOST_TO_WIRED_ROUTING) begin
            out_val_r <= host_ctl_in;
            host_val_r <= in_val;
        end else if (link.ctl_from_peer_stb) begin
            if (active == WIRED_TO_RF_ROUTING) begin
                out_val_r <= link.ctl_from_peer;
            end else begin
                host_val_r <= link.ctl_from_peer;
            end
        end
    end
    // Send only on change; slowly changing inputs keep radio traffic low
    // Link data moves only with its strobe, so the peer never sees a glitch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sent_r <= 2'h0;
            link.ctl_to_peer_stb <= 1'b0;
            link.ctl_to_peer <= 2'h0;
        end else begin
            link.ctl_to_peer_stb <= send_now;
            if (send_now) begin
                link.ctl_to_peer <= send_val;
                sent_r <= send_val;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ms_left_r <= 8'h00;
            tick_r <= 32'h0;
        end else if (rx_bad_stop && holdoff_r != 8'h00) begin
            ms_left_r <= holdoff_r;
            tick_r <= 32'h0;
        end else if (ms_left_r != 8'h00) begin
            if (tick_r == 32'(HOLDOFF_MS_CYCLES - 1)) begin
                tick_r <= 32'h0;
                ms_left_r <= ms_left_r - 8'h01;
            end else begin
                tick_r <= tick_r + 32'h1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            route_r <= ROUTE_AUTO;
            channel_r <= CHANNEL_DEF;
            baud_r <= BAUD_DEF;
            holdoff_r <= HOLDOFF_DEF_MS;
            mask_r <= '0;
            prog_rst_r <= 1'b0;
            assign_r <= '{INV_OUT_A_DEF, INV_OUT_B_DEF, INV_IN_A_DEF,
                INV_IN_B_DEF, PIN_OFF, PIN_OFF, PIN_OFF, PIN_OFF,
                PROG_RST_DEF};
        end else if (wr) begin
            if (addr == REG_ROUTE) begin
                route_r <= route_t'(wdata[1:0]);
            end else if (addr == REG_CHANNEL) begin
                channel_r <= wdata[7:0];
            end else if (addr == REG_BAUD) begin
                baud_r <= wdata[23:0];
            end else if (addr == REG_HOLDOFF) begin
                // Out-of-range hold-off is clamped to the top value
                holdoff_r <= (wdata[7:0] > HOLDOFF_MAX_MS) ?
                    HOLDOFF_MAX_MS : wdata[7:0];
            end else if (addr == REG_MASK) begin
                mask_r <= wdata[ST_W-1:0];
            end else if (addr == REG_CTRL) begin
                prog_rst_r <= wdata[0];
            end else if (addr >= 4'h8) begin
                assign_r[addr[2:0]] <= pin_code_t'(wdata[7:0]);
            end
        end
    end
    // Set beats clear when an event lands on the clearing write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~((wr && addr == REG_STATUS) ?
                wdata[ST_W-1:0] : '0)) | events;
        end
    end
    assign rd_mux = (addr == REG_ROUTE) ? {30'h0, route_r} :
        (addr == REG_CHANNEL) ? {24'h0, channel_r} :
        (addr == REG_BAUD) ? {8'h0, baud_r} :
        (addr == REG_HOLDOFF) ? {24'h0, holdoff_r} :
        (addr == REG_STATUS) ? {29'h0, status_r} :
        (addr == REG_MASK) ? {29'h0, mask_r} :
        (addr == REG_CTRL) ? {26'h0, active, 3'h0, prog_rst_r} :
        addr[3] ?
            {24'h0, 8'(assign_r[addr[2:0]])} : 32'h0;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else if (rd) begin
            rdata <= rd_mux;
        end else begin
            rdata <= 32'h0;
        end
    end
endmodule // relay_node
`default_nettype wire

// ### rtl/relay_peer.sv
// Far end of the radio control link: a peer node's control bits
`timescale 1ns/1ns
`default_nettype none
module relay_peer
    import relay_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    relay_if.peer link,
    input wire logic [1:0] peer_out_ctl,
    output logic [1:0] peer_in_ctl
);
    logic [1:0] last_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last_r <= 2'h0;
            peer_in_ctl <= 2'h0;
            link.ctl_from_peer <= 2'h0;
            link.ctl_from_peer_stb <= 1'b0;
        end else begin
            if (link.ctl_to_peer_stb) begin
                peer_in_ctl <= link.ctl_to_peer;
            end
            link.ctl_from_peer_stb <= (peer_out_ctl != last_r);
            link.ctl_from_peer <= peer_out_ctl;
            last_r <= peer_out_ctl;
        end
    end
endmodule // relay_peer
`default_nettype wire

// ### rtl/relay_pkg.sv
// Shared constants and types for the control-signal relay
// Behaviour
// - Control inputs change slowly, two bits each way
// - Host routing sends host bits, shows peer bits
// - Wired routing sends input pins, drives output pins
// - Host-to-wired drives pins, reports input pins back
// - Peer inputs follow this node's outputs, crosswise
// - Inverted pins: logical one is low level
// - Routing select 1..3 forced, 0 automatic default
// - Automatic routing from power sources, live
// - Bit rate defaults 9600, USB side unaffected
// - Radio channel 0..255, default 128
// - Framing error holds receiver off for milliseconds
// - Pin code is port times ten plus bit
// - Inverted defaults: codes 10, 11, 12, 13
// - Non-inverted assignments default to disabled
// - Programming-reset output defaults to code 0
// - Never enable both inputs for one signal
// - Bytes arriving too fast are dropped
// - Serial frames are eight data, one stop
`default_nettype none
package relay_pkg;
    typedef enum logic [1:0] {
        ROUTE_AUTO = 2'h0,
        HOST_TO_RF_ROUTING = 2'h1,
        WIRED_TO_RF_ROUTING = 2'h2,
        HOST_TO_WIRED_ROUTING = 2'h3
    } route_t;
    typedef logic signed [7:0] pin_code_t;
    localparam int CLK_HZ = 125_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam logic [7:0] HOLDOFF_MAX_MS = 8'hFA;
    localparam logic [7:0] HOLDOFF_DEF_MS = 8'h00;
    localparam logic [23:0] BAUD_DEF = 24'h002580;
    localparam logic [7:0] CHANNEL_DEF = 8'h80;
    localparam pin_code_t PIN_OFF = -8'sd1;
    localparam pin_code_t PIN_DIGIT_SCALE = 8'sd10;
    localparam pin_code_t INV_OUT_A_DEF = 8'sd10;
    localparam pin_code_t INV_OUT_B_DEF = 8'sd11;
    localparam pin_code_t INV_IN_A_DEF = 8'sd12;
    localparam pin_code_t INV_IN_B_DEF = 8'sd13;
    localparam pin_code_t PROG_RST_DEF = 8'sd0;
    localparam int NPINS = 24;
    localparam int DATA_BITS = 8;
    localparam logic [3:0] REG_ROUTE = 4'h0;
    localparam logic [3:0] REG_CHANNEL = 4'h1;
    localparam logic [3:0] REG_BAUD = 4'h2;
    localparam logic [3:0] REG_HOLDOFF = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h5;
    localparam logic [3:0] REG_CTRL = 4'h6;
    localparam int ST_W = 3;
    localparam int ST_PEER = 0;
    localparam int ST_FRAME = 1;
    localparam int ST_DROP = 2;
endpackage
`default_nettype wire
